// [rtl/abi_pkg.sv]
/*
 * Shared constants for the adapter bus interface: option register map,
 * field positions, reset values, pin modes and timing counts.
 * Assumes a 10 MHz system clock on both ends.
 */
package abi_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS    = 100;
    localparam int SYNC_RELEASE_NS  = 30;
    localparam int SYNC_RELEASE_CYC = (SYNC_RELEASE_NS / CLK_PERIOD_NS < 1) ? 1 :
                                      SYNC_RELEASE_NS / CLK_PERIOD_NS;
    localparam int CHRDY_MAX_NS     = 3000;
    localparam int CHRDY_MAX_CYC    = CHRDY_MAX_NS / CLK_PERIOD_NS;
    localparam int WAIT_MARGIN_CYC  = 4;
    localparam int SYNC_STAGES      = 2;

    // ****************************************************************
    // Bus widths
    // ****************************************************************
    localparam int ADDR_W = 24;
    localparam int MFP_W  = 10;

    // ****************************************************************
    // Option registers, indexed by the low three address bits
    // ****************************************************************
    localparam logic [15:0] POS_BASE   = 16'h0100;
    localparam logic [2:0]  POS_ID_LO  = 3'h0;
    localparam logic [2:0]  POS_ID_HI  = 3'h1;
    localparam logic [2:0]  POS_REG102 = 3'h2;
    localparam logic [2:0]  POS_REG103 = 3'h3;
    localparam logic [2:0]  POS_REG104 = 3'h4;
    localparam logic [2:0]  POS_REG105 = 3'h5;
    localparam int CARD_EN_BIT    = 0;
    localparam int SYNC_READY_BIT = 5;
    localparam int ERR_STAT_BIT   = 7;
    localparam logic [7:0] REG102_RESET = 8'h00;
    localparam logic [7:0] REG105_RESET = 8'h80;

    // ****************************************************************
    // Multi-function pin modes
    // ****************************************************************
    localparam logic [1:0] PIN_MODE0 = 2'h0;
    localparam logic [1:0] PIN_MODE1 = 2'h1;

    // ****************************************************************
    // Adapter-side APB register map
    // ****************************************************************
    localparam logic [7:0] ADP_CTRL   = 8'h00;
    localparam logic [7:0] ADP_BASE   = 8'h04;
    localparam logic [7:0] ADP_STATUS = 8'h08;
    localparam int CTRL_SLOW_MEM = 0;
    localparam int CTRL_SLOW_IO  = 1;
    localparam int CTRL_STROBE   = 2;
    localparam int CTRL_MEM16    = 3;
    localparam int CTRL_IO16     = 4;
    localparam int CTRL_ERROR    = 5;
    localparam int CTRL_RELOC    = 6;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] BASE_RESET = 32'h0000_0000;

endpackage : abi_pkg

// [rtl/abi_link_if.sv]
/*
 * Link between the bus interface device and the adapter card logic.
 * Assumes both ends run on the same clock; active-low signals end in _n.
 */
`timescale 1ns/1ns
interface abi_link_if import abi_pkg::*; ();
    logic              mem_rd_n;
    logic              mem_wr_n;
    logic              io_rd_n;
    logic              io_wr_n;
    logic              low_byte_xcvr_enable_n;
    logic              high_byte_xcvr_enable_n;
    logic              xcvr_direction;
    logic              card_enabled_out;
    logic [MFP_W-1:0]  multifunction_outputs;
    logic [ADDR_W-1:0] addr;
    logic              mem_io;
    logic              adapter_ready_in_n;
    logic              ready_release_strobe;
    logic              data_size_wide_n;
    logic              card_select_n;
    logic              error_n;

    modport dev (
        output mem_rd_n, mem_wr_n, io_rd_n, io_wr_n,
        output low_byte_xcvr_enable_n, high_byte_xcvr_enable_n, xcvr_direction,
        output card_enabled_out, multifunction_outputs, addr, mem_io,
        input  adapter_ready_in_n, ready_release_strobe, data_size_wide_n,
        input  card_select_n, error_n
    );
    modport adp (
        input  mem_rd_n, mem_wr_n, io_rd_n, io_wr_n,
        input  low_byte_xcvr_enable_n, high_byte_xcvr_enable_n, xcvr_direction,
        input  card_enabled_out, multifunction_outputs, addr, mem_io,
        output adapter_ready_in_n, ready_release_strobe, data_size_wide_n,
        output card_select_n, error_n
    );
endinterface : abi_link_if

// [rtl/abi_device.sv]
/*
 * Adapter bus interface device: decodes bus status and command into
 * strobes, controls data transceivers, extends cycles, reports errors
 * and holds the option registers.
 * Assumes bus pins are asynchronous to clk_i and the adapter logic is
 * on clk_i.
 */
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module abi_device
    import abi_pkg::*;
#(
    parameter logic [15:0] CARD_ID = 16'h6A5C  // Arbitrary value.
) (
    input  wire logic              clk_i,
    input  wire logic              reset_i,
    input  wire logic              status0_n_i,
    input  wire logic              status1_n_i,
    input  wire logic              mem_io_i,
    input  wire logic              cmd_n_i,
    input  wire logic              setup_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        bus_data_i,
    input  wire logic [1:0]        pin_mode_i,
    output logic [7:0]             bus_data_o,
    output logic                   bus_data_oe_n_o,
    output logic                   channel_ready_o,
    output logic                   channel_check_n_o,
    output logic                   data_size_16_n_o,
    output logic                   card_feedback_n_o,
    abi_link_if.dev                link
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    localparam int RAW_W = 5 + ADDR_W + 8 + 2;

    typedef enum {RDY_IDLE, RDY_EXTEND, RDY_SYNC_REL, RDY_DONE} abi_rdy_type;

    logic [RAW_W-1:0]  sync_meta;
    logic [RAW_W-1:0]  sync_out;
    logic              s0_n;
    logic              s1_n;
    logic              mio;
    logic              cmd_n;
    logic              setup_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic [1:0]        strap;

    always_ff @(posedge clk_i) begin
        sync_meta <= {status0_n_i, status1_n_i, mem_io_i, cmd_n_i, setup_n_i,
                      addr_i, bus_data_i, pin_mode_i};
        sync_out  <= sync_meta;
    end

    assign {s0_n, s1_n, mio, cmd_n, setup_n, addr, wdata, strap} = sync_out;

    // ****************************************************************
    // Cycle decode
    // ****************************************************************
    logic       wr_cyc;
    logic       rd_cyc;
    logic       cmd_act;
    logic       cmd_act_q;
    logic       cmd_fall;
    logic       normal;
    logic       selected;
    logic       xcvr_on;
    logic       pos_acc;
    logic [2:0] pos_idx;
    logic [7:0] reg102;
    logic [7:0] reg103;
    logic [7:0] reg104;
    logic [7:0] reg105;
    logic       err_latched;
    logic [1:0] pin_mode;

    assign wr_cyc   = ~s0_n;
    assign rd_cyc   = ~s1_n;
    assign cmd_act  = ~cmd_n;
    assign cmd_fall = cmd_act & ~cmd_act_q;
    assign normal   = reg102[CARD_EN_BIT] & setup_n;
    assign selected = normal & ~link.card_select_n;
    assign xcvr_on  = selected & (wr_cyc | rd_cyc);
    assign pos_idx  = addr[2:0];
    assign pos_acc  = ~setup_n & ~mio & (addr[15:3] == POS_BASE[15:3]);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cmd_act_q <= 1'b0;
        end else begin
            cmd_act_q <= cmd_act;
        end
    end

    // ****************************************************************
    // Adapter strobes and transceiver control
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.mem_rd_n                <= 1'b1;
            link.mem_wr_n                <= 1'b1;
            link.io_rd_n                 <= 1'b1;
            link.io_wr_n                 <= 1'b1;
            link.low_byte_xcvr_enable_n  <= 1'b1;
            link.high_byte_xcvr_enable_n <= 1'b1;
            link.xcvr_direction          <= 1'b0;
            link.addr                    <= '0;
            link.mem_io                  <= 1'b0;
        end else begin
            link.mem_rd_n <= ~(normal & cmd_act & mio & rd_cyc);
            link.mem_wr_n <= ~(normal & cmd_act & mio & wr_cyc);
            link.io_rd_n  <= ~(normal & cmd_act & ~mio & rd_cyc);
            link.io_wr_n  <= ~(normal & cmd_act & ~mio & wr_cyc);
            link.low_byte_xcvr_enable_n  <= ~xcvr_on;
            link.high_byte_xcvr_enable_n <= ~(xcvr_on & ~link.data_size_wide_n);
            link.xcvr_direction          <= wr_cyc;
            link.addr                    <= addr;
            link.mem_io                  <= mio;
        end
    end

    // Only 8 and 16 bit paths exist; the size input picks between them.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            data_size_16_n_o  <= 1'b1;
            card_feedback_n_o <= 1'b1;
        end else begin
            data_size_16_n_o  <= ~(selected & ~link.data_size_wide_n);
            card_feedback_n_o <= ~selected;
        end
    end

    // ****************************************************************
    // Extended cycle control
    // ****************************************************************
    abi_rdy_type rdy_state;
    logic [3:0]  rel_cnt;
    logic        strobe_q;
    logic        strobe_rise;
    logic        sync_mode;

    assign strobe_rise = link.ready_release_strobe & ~strobe_q;
    assign sync_mode   = reg105[SYNC_READY_BIT];

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            strobe_q <= 1'b0;
        end else begin
            strobe_q <= link.ready_release_strobe;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            rdy_state       <= RDY_IDLE;
            channel_ready_o <= 1'b1;
            rel_cnt         <= '0;
        end else begin
            case (rdy_state)
                RDY_IDLE: begin
                    if (selected & (wr_cyc | rd_cyc) & ~link.adapter_ready_in_n) begin
                        channel_ready_o <= 1'b0;
                        rdy_state       <= RDY_EXTEND;
                    end
                end
                RDY_EXTEND: begin
                    if (~(wr_cyc | rd_cyc) & ~cmd_act) begin
                        channel_ready_o <= 1'b1;
                        rdy_state       <= RDY_IDLE;
                    end else if (sync_mode) begin
                        if (cmd_fall) begin
                            rel_cnt   <= '0;
                            rdy_state <= RDY_SYNC_REL;
                        end
                    end else if (strobe_rise) begin
                        channel_ready_o <= 1'b1;
                        rdy_state       <= RDY_DONE;
                    end
                end
                RDY_SYNC_REL: begin
                    rel_cnt <= rel_cnt + 4'd1;
                    if (rel_cnt == 4'(SYNC_RELEASE_CYC - 1)) begin
                        channel_ready_o <= 1'b1;
                        rdy_state       <= RDY_DONE;
                    end
                end
                RDY_DONE: begin
                    if (~(wr_cyc | rd_cyc) & ~cmd_act) begin
                        rdy_state <= RDY_IDLE;
                    end
                end
                default: begin
                    channel_ready_o <= 1'b1;
                    rdy_state       <= RDY_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Option registers
    // ****************************************************************
    logic pos_wr;

    assign pos_wr = pos_acc & wr_cyc & cmd_fall;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            reg102 <= REG102_RESET;
            reg103 <= '0;
            reg104 <= '0;
            reg105 <= REG105_RESET;
        end else if (pos_wr) begin
            case (pos_idx)
                POS_REG102: reg102 <= wdata;
                POS_REG103: reg103 <= wdata;
                POS_REG104: reg104 <= wdata;
                POS_REG105: reg105 <= wdata;
                default:    reg102 <= reg102;
            endcase
        end
    end

    // An error arriving with a clearing write stays latched.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            err_latched <= 1'b0;
        end else if (~link.error_n) begin
            err_latched <= 1'b1;
        end else if (pos_wr & (pos_idx == POS_REG105) & wdata[ERR_STAT_BIT]) begin
            err_latched <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            channel_check_n_o <= 1'b1;
        end else begin
            channel_check_n_o <= ~(err_latched | ~link.error_n);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            bus_data_o      <= '0;
            bus_data_oe_n_o <= 1'b1;
        end else begin
            bus_data_oe_n_o <= ~(pos_acc & rd_cyc & cmd_act);
            case (pos_idx)
                POS_ID_LO:  bus_data_o <= CARD_ID[7:0];
                POS_ID_HI:  bus_data_o <= CARD_ID[15:8];
                POS_REG102: bus_data_o <= reg102;
                POS_REG103: bus_data_o <= reg103;
                POS_REG104: bus_data_o <= reg104;
                POS_REG105: bus_data_o <= {~err_latched, 1'b0, reg105[5:0]};
                default:    bus_data_o <= '0;
            endcase
        end
    end

    // ****************************************************************
    // Card enable and multi-function outputs
    // ****************************************************************
    logic io_match;
    logic mem_match;

    assign io_match  = ~mio & (addr[15:8] == reg103);
    assign mem_match = mio & (addr[ADDR_W-1:ADDR_W-8] == reg104);

    // The strap is caught while reset is held, never changed afterwards.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pin_mode <= strap;
        end
    end

    // Match outputs go out on multi-function pins 1:0 in mode 0; mode 1 carries the I/O match only.
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.card_enabled_out      <= 1'b0;
            link.multifunction_outputs <= '0;
        end else begin
            link.card_enabled_out <= reg102[CARD_EN_BIT];
            case (pin_mode)
                PIN_MODE0: link.multifunction_outputs <=
                    {reg104[3:0], reg103[3:0], mem_match, io_match};
                PIN_MODE1: link.multifunction_outputs <=
                    {reg103, 1'b0, io_match};
                default:   link.multifunction_outputs <= {reg102[7:1], 3'b000};
            endcase
        end
    end

endmodule : abi_device

// [rtl/abi_adapter.sv]
/*
 * Adapter card logic end: address decode, card select, data size,
 * wait generation and error raising, steered over an APB slave.
 * Assumes the device end shares clk_i.
 */
`timescale 1ns/1ns
module abi_adapter
    import abi_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    abi_link_if.adp          link
);

    // ****************************************************************
    // APB registers
    // ****************************************************************
    logic [31:0] ctrl;
    logic [31:0] base;
    logic [15:0] ext_count;
    logic        access;

    assign access = psel_i & penable_i & ~pready_o;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl      <= CTRL_RESET;
            base      <= BASE_RESET;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= '0;
        end else begin
            pready_o  <= access;
            pslverr_o <= 1'b0;
            if (access) begin
                case (paddr_i)
                    ADP_CTRL: begin
                        prdata_o <= ctrl;
                        if (pwrite_i) ctrl <= pwdata_i;
                    end
                    ADP_BASE: begin
                        prdata_o <= base;
                        if (pwrite_i) base <= pwdata_i;
                    end
                    ADP_STATUS: begin
                        prdata_o <= {ext_count, 5'd0, link.multifunction_outputs,
                                     link.card_enabled_out};
                    end
                    default: begin
                        prdata_o  <= '0;
                        pslverr_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Address decode and wait generation
    // ****************************************************************
    localparam logic [7:0] WAIT_LIMIT = 8'(CHRDY_MAX_CYC - WAIT_MARGIN_CYC);

    logic       mem_hit;
    logic       io_hit;
    logic       hit;
    logic       slow;
    logic [7:0] wait_cnt;
    logic [7:0] wait_lim;
    logic       wait_done;
    logic       ready_q;

    assign mem_hit = link.card_enabled_out & link.mem_io &
                     (link.addr[ADDR_W-1:ADDR_W-8] == base[7:0]);
    assign io_hit  = link.card_enabled_out & ~link.mem_io &
                     (link.addr[15:4] == base[19:8]);
    assign hit     = mem_hit | io_hit |
                     (ctrl[CTRL_RELOC] & link.card_enabled_out &
                      (link.multifunction_outputs[0] | link.multifunction_outputs[1]));
    assign slow    = (mem_hit & ctrl[CTRL_SLOW_MEM]) | (io_hit & ctrl[CTRL_SLOW_IO]);
    assign wait_lim  = (ctrl[15:8] > WAIT_LIMIT) ? WAIT_LIMIT : ctrl[15:8];
    assign wait_done = (wait_cnt >= wait_lim);

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wait_cnt <= '0;
        end else if (slow) begin
            if (!wait_done) wait_cnt <= wait_cnt + 8'd1;
        end else begin
            wait_cnt <= '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            link.card_select_n        <= 1'b1;
            link.data_size_wide_n     <= 1'b1;
            link.adapter_ready_in_n   <= 1'b1;
            link.ready_release_strobe <= 1'b0;
            link.error_n              <= 1'b1;
        end else begin
            link.card_select_n    <= ~hit;
            link.data_size_wide_n <= ~(mem_hit ? ctrl[CTRL_MEM16] : ctrl[CTRL_IO16]);
            link.adapter_ready_in_n   <= ~(slow & ~wait_done);
            link.ready_release_strobe <= ctrl[CTRL_STROBE] & slow & wait_done;
            link.error_n              <= ~ctrl[CTRL_ERROR];
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ready_q   <= 1'b1;
            ext_count <= '0;
        end else begin
            ready_q <= link.adapter_ready_in_n;
            if (ready_q & ~link.adapter_ready_in_n) ext_count <= ext_count + 16'd1;
        end
    end

endmodule : abi_adapter

// [bench/abi_link_sva.sv]
/*
 * Checker for the link between the device and the adapter logic.
 * Assumes one clock and a synchronous active-high reset; the bench instantiates it.
 */
`timescale 1ns/1ns
module abi_link_sva (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic mem_rd_n,
    input wire logic mem_wr_n,
    input wire logic io_rd_n,
    input wire logic io_wr_n,
    input wire logic high_byte_xcvr_enable_n,
    input wire logic xcvr_direction,
    input wire logic card_enabled_out,
    input wire logic data_size_wide_n,
    input wire logic card_select_n
);
    logic [3:0] stb;
    assign stb = {mem_rd_n, mem_wr_n, io_rd_n, io_wr_n};
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    a_one_strobe: assert property ($onehot0(~stb))
        else $error("more than one strobe active");
    a_strobe_enabled: assert property (!(&stb) |-> card_enabled_out)
        else $error("strobe while card disabled");
    a_dir_write: assert property (!(mem_wr_n && io_wr_n) |-> xcvr_direction)
        else $error("direction low on write");
    a_dir_read: assert property (!(mem_rd_n && io_rd_n) |-> !xcvr_direction)
        else $error("direction high on read");
    a_high_wide: assert property ($fell(high_byte_xcvr_enable_n) |->
        !$past(data_size_wide_n) || !$past(data_size_wide_n, 2) || !$past(data_size_wide_n, 3))
        else $error("high byte enabled without wide size");
    a_high_enabled: assert property (!high_byte_xcvr_enable_n |-> card_enabled_out)
        else $error("high byte enabled while card disabled");
    a_enable_reset: assert property ($fell(reset_i) |-> !card_enabled_out)
        else $error("card enabled after reset");
    a_select_enabled: assert property (!card_select_n |-> $past(card_enabled_out))
        else $error("card selected while disabled");
    cover property (!mem_rd_n);
    cover property (!io_wr_n);
    cover property (!high_byte_xcvr_enable_n);
    cover property ($rose(card_enabled_out));
endmodule : abi_link_sva

// [bench/tb_adapter_bus_interface.sv]
/*
 * Self-checking bench joining the device and adapter ends over the link.
 * Assumes a 10 MHz clock; the bench plays bus host and APB master.
 */
`timescale 1ns/1ns
module tb_adapter_bus_interface import abi_pkg::*; ;
    logic        clk_i = 0, reset_i = 1, st0 = 1, st1 = 1, mio = 0, cmd = 1, su = 1;
    logic [23:0] ad = '0;
    logic [7:0]  bd = '0, rd, pa = '0, bdo;
    logic        psel = 0, pen = 0, pwr = 0, perr, dir, pready, pslv, chk_n, w, m, rdy;
    logic [1:0]  pm = 2'h0;
    logic [31:0] pwd = '0, prd, prdata;
    logic [3:0]  s, e;
    int          fails = 0, num_checks = 0, cyc_cnt = 0, lowc = 0, low0 = 0;
    abi_link_if lk ();
    abi_device i_abi_device (.clk_i(clk_i), .reset_i(reset_i), .status0_n_i(st0),
        .status1_n_i(st1), .mem_io_i(mio), .cmd_n_i(cmd), .setup_n_i(su), .addr_i(ad),
        .bus_data_i(bd), .pin_mode_i(pm), .bus_data_o(bdo), .bus_data_oe_n_o(),
        .channel_ready_o(rdy), .channel_check_n_o(chk_n), .data_size_16_n_o(),
        .card_feedback_n_o(), .link(lk));
    abi_adapter i_abi_adapter (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslv), .link(lk));
    abi_link_sva i_abi_link_sva (.clk_i(clk_i), .reset_i(reset_i), .mem_rd_n(lk.mem_rd_n),
        .mem_wr_n(lk.mem_wr_n), .io_rd_n(lk.io_rd_n), .io_wr_n(lk.io_wr_n),
        .high_byte_xcvr_enable_n(lk.high_byte_xcvr_enable_n),
        .xcvr_direction(lk.xcvr_direction), .card_enabled_out(lk.card_enabled_out),
        .data_size_wide_n(lk.data_size_wide_n), .card_select_n(lk.card_select_n));
    initial forever #50 clk_i = ~clk_i;
    // Counts the edges at which the channel-ready line holds a cycle extended.
    always @(posedge clk_i) if (rdy === 1'b0) lowc <= lowc + 1;
    task report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            fails++;
            report_and_stop;
        end
    end
    task chk(input string n, input logic [31:0] ex, input logic [31:0] v);
        num_checks++;
        if (v !== ex) begin
            $display("wrong value %s expected %h seen %h", n, ex, v);
            fails++;
        end
    endtask : chk
    // One bus cycle; strobes, direction and option read data are taken on the last edge of the command.
    task cyc(input logic wr, input logic mm, input logic setup, input logic [23:0] a,
             input logic [7:0] d);
        @(posedge clk_i);
        st0 <= !wr; st1 <= wr; mio <= mm; su <= !setup; ad <= a; bd <= d;
        repeat (3) @(posedge clk_i);
        cmd <= 1'b0;
        repeat (8) @(posedge clk_i);
        s = {lk.mem_rd_n, lk.mem_wr_n, lk.io_rd_n, lk.io_wr_n};
        dir = lk.xcvr_direction;
        rd = bdo;
        cmd <= 1'b1; st0 <= 1'b1; st1 <= 1'b1; su <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask : cyc
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1; pen <= 1'b0; pwr <= wr; pa <= a; pwd <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        prd = prdata;
        perr = pslv;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    initial begin
        void'($urandom(32'h85bc_948f));
        pm <= {1'b0, 1'($urandom)};
        repeat (12) @(posedge clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk("card_enabled", 0, lk.card_enabled_out);
        cyc(0, 0, 1, 24'h00_0105, 8'h00);
        chk("reg105", 8'h80, rd);
        cyc(1, 0, 1, 24'h00_0102, 8'h01);
        chk("card_enabled", 1, lk.card_enabled_out);
        apb(1, ADP_CTRL, 32'h0000_0008);
        for (int i = 0; i < 8; i++) begin
            w = i[0];
            m = i[1];
            cyc(w, m, 0, {8'h00, 16'($urandom)}, 8'($urandom));
            e = 4'hF;
            e[3 - {!m, w}] = 1'b0;
            chk("strobes", e, s);
            chk("direction", w, dir);
        end
        // Synchronous extension: slow memory, six waits, release strobe left low.
        apb(1, ADP_CTRL, 32'h0000_0609);
        cyc(1, 0, 1, 24'h00_0105, 8'h20);
        low0 = lowc;
        cyc(0, 1, 0, 24'h00_1234, 8'h00);
        chk("sync_ext", SYNC_RELEASE_CYC + 1, lowc - low0);
        // Asynchronous extension: the release strobe ends the extended cycle.
        apb(1, ADP_CTRL, 32'h0000_060D);
        cyc(1, 0, 1, 24'h00_0105, 8'h00);
        low0 = lowc;
        cyc(0, 1, 0, 24'h00_1234, 8'h00);
        chk("async_ext", 1, (lowc - low0) > SYNC_RELEASE_CYC + 1);
        chk("ready_limit", 1, (lowc - low0) <= CHRDY_MAX_CYC);
        chk("ready_end", 1, rdy);
        apb(0, ADP_STATUS, 32'h0000_0000);
        chk("status", pm[0] ? 32'h0000_0001 : 32'h0000_0005, prd & 32'h0000_07FF);
        apb(0, 8'h0C, 32'h0000_0000);
        chk("slverr", 1, perr);
        apb(1, ADP_CTRL, 32'h0000_0020);
        apb(0, ADP_CTRL, 32'h0000_0000);
        chk("ctrl", 32'h0000_0020, prd);
        repeat (3) @(posedge clk_i);
        chk("check_n", 0, chk_n);
        cyc(0, 0, 1, 24'h00_0105, 8'h00);
        chk("error_bit", 0, rd[7]);
        cyc(1, 0, 1, 24'h00_0102, 8'h00);
        cyc(0, 1, 0, 24'h00_3456, 8'h00);
        chk("strobes_off", 4'hF, s);
        report_and_stop;
    end
endmodule : tb_adapter_bus_interface
